// [design/pdm_mic_out.sv]
// pdm microphone data output port: modulator, two-entry buffer, slot driver, sleep
`timescale 1ns/1ps

module pdm_mic_out
   import pdm_pkg::*;
(
   // system
   input  wire logic        sys_clk_i,
   input  wire logic        resetn_i,
   // link pins
   input  wire logic        bit_clk_i,
   input  wire logic        lr_strap_i,
   output      logic        data_o,
   output      logic        data_oe_o,
   // signed sample in from the analog front end, offset binary
   input  wire logic [15:0] sample_i,
   input  wire logic        sample_valid_i,
   output      logic        sample_ready_o,
   // status
   output      logic        asleep_o
);

   // ***************************
   // helpers
   // ***************************
   function automatic logic [16:0] add17(input logic [15:0] a, input logic [15:0] b);
      add17 = {1'b0, a} + {1'b0, b};
   endfunction

   // ***************************
   // edges and strap
   // ***************************
   logic        clk_q;
   logic        rise;
   logic        fall;
   logic        left_sel;
   logic        launch;

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         clk_q <= 1'h0;
      end else begin
         clk_q <= bit_clk_i;
      end
   end

   assign rise = bit_clk_i & ~clk_q;
   assign fall = ~bit_clk_i & clk_q;

   // strap is static; caught each cycle after release, never under reset
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         left_sel <= STRAP_LEFT;
      end else begin
         left_sel <= lr_strap_i;
      end
   end

   // own-slot edge launches, opposite edge releases
   assign launch = left_sel ? fall : rise;

   // ***************************
   // sleep detection
   // ***************************
   pdm_state_t              state;
   pdm_state_t              next_state;
   logic [SLEEP_CNT_W-1:0]  idle_cnt;
   logic                    slow;

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         idle_cnt <= '0;
      end else if (rise | fall) begin
         idle_cnt <= '0;
      end else if (!slow) begin
         idle_cnt <= idle_cnt + 24'h000001;
      end
   end

   // no edge for a full period of the threshold frequency means sleep
   assign slow = (idle_cnt >= SLEEP_CNT_W'(SLEEP_CYCLES));

   always_comb begin
      case (state)
         PDM_SLEEP: next_state = rise ? PDM_IDLE : PDM_SLEEP;
         PDM_IDLE:  next_state = slow ? PDM_SLEEP : (launch ? PDM_RUN : PDM_IDLE);
         PDM_RUN:   next_state = slow ? PDM_SLEEP : PDM_RUN;
         default:   next_state = PDM_SLEEP;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         state <= PDM_SLEEP;
      end else begin
         state <= next_state;
      end
   end

   // ***************************
   // modulator
   // ***************************
   // first-order sigma-delta, no dither (lfsr steps but feeds nothing); the full fourth-order loop lives
   // in the analog domain, this keeps the density law and the idle pattern
   logic [15:0] acc;
   logic [15:0] lfsr;
   logic [16:0] sum;
   logic        mod_valid;
   logic        mod_ready;
   logic [15:0] cur_sample;

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         cur_sample <= SAMPLE_RESET;
      end else if (sample_valid_i) begin
         cur_sample <= sample_i;
      end
   end
   assign sample_ready_o = 1'b1;

   assign sum       = add17(acc, cur_sample);
   assign mod_valid = (state != PDM_SLEEP);

   // carry out is the bit: mid-scale alternates 0,1,0,1
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         acc <= ACC_RESET;
      end else if (mod_valid && mod_ready) begin
         acc <= sum[15:0];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         lfsr <= LFSR_SEED;
      end else if (mod_valid && mod_ready) begin
         lfsr <= lfsr[0] ? ((lfsr >> 1) ^ LFSR_TAPS) : (lfsr >> 1);
      end
   end

   // ***************************
   // two-entry buffer
   // ***************************
   // a stall at the pin side loses no bit; the modulator waits on mod_ready
   pdm_bit_t    buf_mem [2];
   logic        wr_ptr;
   logic        rd_ptr;
   logic [1:0]  count;
   logic        pop;
   logic        push;
   logic        out_valid;

   assign mod_ready = (count != BUF_DEPTH);
   assign push      = mod_valid & mod_ready;
   assign out_valid = (count != 2'h0);
   assign pop       = out_valid & launch & (state != PDM_SLEEP);

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         buf_mem[0] <= '0;
         buf_mem[1] <= '0;
      end else if (push) begin
         buf_mem[wr_ptr] <= '{valid: 1'b1, bit_val: sum[16]};
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count  <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end

   // ***************************
   // slot driver
   // ***************************
   pdm_pin_t    pin;

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         pin <= '0;
      end else if (next_state == PDM_SLEEP) begin
         pin.drive_en <= 1'b0;
      end else if (pop) begin
         pin <= '{drive_en: 1'b1, level: buf_mem[rd_ptr].bit_val};
      end else if (left_sel ? rise : fall) begin
         // level holds so a lone device's line only moves on its own edge
         pin.drive_en <= 1'b0;
      end
   end

   assign data_o    = pin.level;
   assign data_oe_o = pin.drive_en;
   assign asleep_o  = (state == PDM_SLEEP);

endmodule

// [pkg/pdm_pkg.sv]
// package for the pdm microphone output port: constants and carrier types
package pdm_pkg;

   // ***************************
   // timing
   // ***************************
   localparam int unsigned SYS_CLK_HZ     = 100_000_000;
   localparam int unsigned SLEEP_FREQ_HZ  = 1_000;
   // longest bit-clock half period that still counts as running, in system cycles
   localparam int unsigned SLEEP_CYCLES   = SYS_CLK_HZ / SLEEP_FREQ_HZ;
   localparam int unsigned SLEEP_CNT_W    = 24;

   // ***************************
   // reset values and encodings
   // ***************************
   localparam logic        STRAP_LEFT     = 1'h1;
   localparam logic [1:0]  BUF_DEPTH      = 2'h2;
   localparam logic [15:0] LFSR_SEED      = 16'hace1;
   localparam logic [15:0] LFSR_TAPS      = 16'hb400;
   localparam logic [15:0] ACC_RESET      = 16'h0000;
   localparam logic [15:0] SAMPLE_RESET   = 16'h8000;

   // one output bit on its way to the pin
   typedef struct packed {
      logic valid;
      logic bit_val;
   } pdm_bit_t;

   // pin drive pair for the shared data line
   typedef struct packed {
      logic drive_en;
      logic level;
   } pdm_pin_t;

   typedef enum logic [2:0] {
      PDM_SLEEP = 3'h1,
      PDM_RUN   = 3'h2,
      PDM_IDLE  = 3'h4
   } pdm_state_t;

endpackage

// [tb/pdm_ctrl_model.sv]
// controller model: makes the bit clock and captures one slot
`timescale 1ns/1ps
module pdm_ctrl_model #(parameter int HALF = 20)
(
   input  wire logic sys_clk_i,
   input  wire logic run_i,
   input  wire logic left_i,
   input  wire logic line_i,
   output logic      bit_clk_o = 1'b0,
   output logic      cap_o = 1'b0,
   output logic      cap_stb_o = 1'b0
);
   int cnt = 0;
   // stopping finishes a high phase, so the clock stands low between runs
   always @(posedge sys_clk_i) begin
      cap_stb_o <= 1'b0;
      if (run_i || bit_clk_o) begin
         cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
         if (cnt == HALF - 1) begin
            bit_clk_o <= ~bit_clk_o;
            if (bit_clk_o != left_i) begin
               cap_o     <= line_i;
               cap_stb_o <= 1'b1;
            end
         end
      end
   end
endmodule

// [tb/pdm_props.sv]
// checker for the pdm microphone output port
`timescale 1ns/1ps
module pdm_props
   import pdm_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic bit_clk_i,
   input wire logic lr_strap_i,
   input wire logic data_o,
   input wire logic data_oe_o,
   input wire logic asleep_o
);
   // ***********
   // assertions
   // ***********
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   logic        clk_q;
   logic [23:0] idle;
   // cycles since the last bit-clock edge; saturation is not needed within one run
   always_ff @(posedge sys_clk_i) begin
      clk_q <= bit_clk_i;
      idle  <= (!resetn_i || bit_clk_i != clk_q) ? 24'h0 : idle + 24'h1;
   end
   a_right_release: assert property (!lr_strap_i && $fell(bit_clk_i) |=> !data_oe_o)
      else $error("right slot held past falling edge");
   a_left_release: assert property (lr_strap_i && $rose(bit_clk_i) |=> !data_oe_o)
      else $error("left slot held past rising edge");
   a_right_edge: assert property (!lr_strap_i && $changed(data_o) |-> $past(bit_clk_i))
      else $error("right data moved off rising edge");
   a_left_edge: assert property (lr_strap_i && $changed(data_o) |-> !$past(bit_clk_i))
      else $error("left data moved off falling edge");
   a_one_edge: assert property ($changed(data_o) |-> $past(bit_clk_i) != $past(bit_clk_i, 2))
      else $error("data moved without a clock edge");
   a_own_slot: assert property (data_oe_o |-> $past(bit_clk_i) == !lr_strap_i)
      else $error("line driven in foreign slot");
   a_sleep_hold: assert property (asleep_o |-> !data_oe_o)
      else $error("line driven while asleep");
   a_sleep_entry: assert property (idle > 24'(SLEEP_CYCLES + 3) |-> asleep_o)
      else $error("no sleep after clock stopped");
endmodule

// [tb/tb_top.sv]
// testbench for the pdm microphone output port
`timescale 1ns/1ps
module tb_top;
   import pdm_pkg::*;
   logic        sys_clk_i = 1'b0;
   logic        resetn_i = 1'b0;
   logic        lr_strap_i = 1'b0;
   logic [15:0] sample_i = 16'h8000;
   logic        sample_valid_i = 1'b0;
   logic        run = 1'b0;
   logic        bit_clk_i, data_o, data_oe_o, sample_ready_o, asleep_o, cap, cap_stb, line;
   int          n_fail = 0;
   int          tests_run = 0;
   always #5 sys_clk_i = ~sys_clk_i;
   // no pull on the line: a released line shows the inverse of the last bit
   assign line = data_oe_o ? data_o : ~data_o;
   pdm_mic_out dut_u (.sys_clk_i, .resetn_i, .bit_clk_i, .lr_strap_i, .data_o, .data_oe_o,
      .sample_i, .sample_valid_i, .sample_ready_o, .asleep_o);
   pdm_ctrl_model ctl_u (.sys_clk_i, .run_i(run), .left_i(lr_strap_i), .line_i(line),
      .bit_clk_o(bit_clk_i), .cap_o(cap), .cap_stb_o(cap_stb));
   // ***********
   // tasks
   // ***********
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   task automatic start(logic left, logic [15:0] s);
      run = 1'b0;
      resetn_i = 1'b0;
      lr_strap_i = left;
      sample_i = s;
      cyc(50);
      resetn_i = 1'b1;
      sample_valid_i = 1'b1;
      cyc(1);
      sample_valid_i = 1'b0;
      check("asleep", {15'h0, asleep_o}, 16'h1);
      check("oe", {15'h0, data_oe_o}, 16'h0);
      run = 1'b1;
   endtask
   task automatic get_bit(output logic b);
      int i;
      for (i = 0; i < 200 && cap_stb !== 1'b1; i++) cyc(1);
      if (cap_stb !== 1'b1) begin
         n_fail++;
         tally_and_finish();
      end
      b = cap;
      cyc(1);
   endtask
   task automatic t_zero(logic left);
      logic a, b;
      start(left, 16'h8000);
      repeat (6) get_bit(a);
      repeat (16) begin
         get_bit(b);
         check("alternation", {15'h0, b}, {15'h0, ~a});
         a = b;
      end
      $display("zero amplitude test done, left %0d", left);
   endtask
   task automatic t_dense(logic [15:0] s, logic [15:0] lo, logic [15:0] hi);
      logic b;
      int   ones;
      ones = 0;
      start(1'b0, s);
      repeat (6) get_bit(b);
      repeat (32) begin
         get_bit(b);
         ones += int'(b);
      end
      check("ones_in_range", {15'h0, ones >= lo && ones <= hi}, 16'h1);
      $display("density test done, sample %h ones %0d", s, ones);
   endtask
   task automatic t_sleep();
      int i;
      run = 1'b0;
      for (i = 0; i < 100200 && asleep_o !== 1'b1; i++) cyc(1);
      check("sleep_late", {15'h0, i >= SLEEP_CYCLES - 100}, 16'h1);
      check("asleep", {15'h0, asleep_o}, 16'h1);
      check("oe", {15'h0, data_oe_o}, 16'h0);
      $display("sleep test done");
   endtask
   initial begin
      cyc(4);
      resetn_i = 1'b1;
      cyc(1);
      check("ready", {15'h0, sample_ready_o}, 16'h1);
      t_zero(1'b0);
      t_zero(1'b1);
      t_dense(16'hffff, 16'h1e, 16'h20);
      t_dense(16'h0000, 16'h0, 16'h2);
      t_sleep();
      tally_and_finish();
   end
endmodule
bind pdm_mic_out pdm_props chk_u (.sys_clk_i, .resetn_i, .bit_clk_i, .lr_strap_i, .data_o,
   .data_oe_o, .asleep_o);
